//--- dchp_defs.svh
// register offsets, field positions, reset values and timing counts of the host port
`ifndef DCHP_DEFS_SVH
`define DCHP_DEFS_SVH

// register byte offsets
`define DCHP_R_CTRL 8'h00
`define DCHP_R_STAT 8'h04
`define DCHP_R_EVT  8'h08
`define DCHP_R_ITAG 8'h0c
`define DCHP_R_MBI  8'h10
`define DCHP_R_OTAG 8'h14
`define DCHP_R_ADDR 8'h18

// control register fields
`define DCHP_C_LINK  0
`define DCHP_C_HOLD  1
`define DCHP_C_RSVA  2
`define DCHP_C_RSVB  3
`define DCHP_C_DSI   4
`define DCHP_C_MRD   5
`define DCHP_C_TODEV 6
`define DCHP_C_TOHST 7
`define DCHP_C_REL   8
`define DCHP_C_RBSY  9
`define DCHP_C_DIN   10
`define DCHP_C_REQA  11
`define DCHP_C_REQB  12

// status register fields
`define DCHP_S_RTA   0
`define DCHP_S_RTB   1
`define DCHP_S_USE   2
`define DCHP_S_HLDA  3
`define DCHP_S_HLDB  4
`define DCHP_S_BSA   5
`define DCHP_S_BSB   6
`define DCHP_S_FULL  7
`define DCHP_S_RWAIT 8

// event register fields, write one to clear except DCHP_E_INSB, which a write leaves as it is
`define DCHP_E_INS  0
`define DCHP_E_POLL 1
`define DCHP_E_DCN  2
`define DCHP_E_XEND 3
`define DCHP_E_OVR  4
`define DCHP_E_OVR2 5
`define DCHP_E_INSB 6
`define DCHP_E_PROCESS_ERROR 7

// inbound tag register fields, status byte in bits 7:0
`define DCHP_T_ADR 8
`define DCHP_T_STS 9
`define DCHP_T_OPI 10

// reset values and status bytes
`define DCHP_ADDR_RST 5'h00
`define DCHP_STS_CUB  8'h50
`define DCHP_STS_CUE  8'h20

// offset interlock delay
`define DCHP_CLK_NS 10
`define DCHP_OFS_NS 200
`define DCHP_OFS_CYC ((`DCHP_OFS_NS + `DCHP_CLK_NS - 1) / `DCHP_CLK_NS)

`endif

//--- dchp_pkg.sv
// types shared by the host port modules
package dchp_pkg;

  typedef struct packed {
    logic       select_out;
    logic       hold_out;
    logic       address_out;
    logic       command_out;
    logic       service_out;
    logic       data_out;
    logic       operational_out;
    logic       suppress_out;
    logic [7:0] bus_out;
  } dchp_otag_t;

  typedef struct packed {
    logic       drv_en;
    logic       operational_in;
    logic       address_in;
    logic       status_in;
    logic       service_in;
    logic       data_in;
    logic       disconnect_in;
    logic       request_in;
    logic [7:0] bus_in;
  } dchp_itag_t;

  typedef enum logic [1:0] {SD_IDLE, SD_BUSY, SD_DONE} dchp_sd_t;
  typedef enum logic [1:0] {X_IDLE, X_REQ, X_ACK, X_PASS} dchp_xs_t;

  typedef struct packed {
    dchp_sd_t s;
    logic     seen, pend, initial_selection_event, poll, bsent, disc, adr_q;
  } dchp_side_st_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       run, done;
  } dchp_dly_st_t;

  typedef struct packed {
    logic       link_open, lo_q, sw_hold, rsv_a, rsv_b, dsi, mrd;
    logic       to_dev, to_host, rel, rst_busy, use_din, req_a, req_b;
    logic       route_a, route_b, in_use, hold_a, hold_b, process_error;
    logic       ev_ins, ev_poll, ev_dcn, ev_xend, ovr, ovr2, ins_b;
    logic       tag_adr, tag_sts, tag_opi;
    logic [7:0] sts_byte, mbi;
    logic [4:0] cu_addr;
    dchp_otag_t outtag;
    dchp_xs_t   xs;
    logic [7:0] xbuf, fmt_wd;
    logic       full, resp_wait, mbi_go, src_mp, fr_q, xfp;
    logic       hv, hw, rdy;
    logic [7:0] ha;
    logic [31:0] hrdata;
    dchp_itag_t cin_a, cin_b;
  } dchp_st_t;

endpackage

//--- dchp_dly.sv
// fixed delay timer for offset interlock
`timescale 1ns/10ps
`include "dchp_defs.svh"
module dchp_dly (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // control
  input  wire logic start,
  output logic      done
);
  dchp_pkg::dchp_dly_st_t q, n;

  always_comb begin
    n = q;
    n.done = 1'b0;
    if (start) begin
      n.run = 1'b1;
      n.cnt = 8'(`DCHP_OFS_CYC - 1);
    end else if (q.run) begin
      if (q.cnt == 8'h00) begin
        n.run  = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = q.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign done = q.done;
endmodule

//--- dchp_side.sv
// selection, short busy and disconnect detection for one channel side
`timescale 1ns/10ps
`include "dchp_defs.svh"
module dchp_side (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // channel outbound tags
  input  wire dchp_pkg::dchp_otag_t tags,
  // controller state
  input  wire logic [4:0]       cu_addr,
  input  wire logic             poll_mode,
  input  wire logic             busy,
  input  wire logic             hold_off,
  input  wire logic             linked,
  input  wire logic             end_ack,
  // events
  output logic                  initial_selection_event,
  output logic                  poll,
  output logic                  pend,
  output logic                  busy_act,
  output logic                  busy_sent,
  output logic                  disc
);
  dchp_pkg::dchp_side_st_t q, n;
  logic sel;
  logic dreq;

  always_comb begin
    n = q;
    n.initial_selection_event  = 1'b0;
    n.poll = 1'b0;
    n.disc = 1'b0;
    sel = tags.select_out & tags.hold_out & tags.address_out & tags.operational_out
          & (tags.bus_out[7:3] == cu_addr);
    dreq = tags.address_out & ~tags.select_out;
    n.adr_q = dreq;
    n.disc = linked & dreq & ~q.adr_q;
    if (!tags.select_out) begin
      n.seen = 1'b0;
      n.pend = 1'b0;
    end
    if (end_ack) begin
      n.bsent = 1'b0;
    end
    unique case (q.s)
      dchp_pkg::SD_IDLE: begin
        if (sel && !q.seen) begin
          n.seen = 1'b1;
          if (busy && hold_off) begin
            n.pend = 1'b1;
          end else if (busy) begin
            n.s     = dchp_pkg::SD_BUSY;
            n.bsent = 1'b1;
          end else if (poll_mode) begin
            n.poll = 1'b1;
          end else begin
            n.initial_selection_event = 1'b1;
          end
        end else if (q.pend && sel && !busy && !hold_off) begin
          n.pend = 1'b0;
          n.initial_selection_event  = 1'b1;
        end
      end
      dchp_pkg::SD_BUSY: begin
        if (tags.service_out || tags.command_out) begin
          n.s = dchp_pkg::SD_DONE;
        end
      end
      dchp_pkg::SD_DONE: begin
        if (!tags.select_out && !tags.address_out) begin
          n.s = dchp_pkg::SD_IDLE;
        end
      end
      default: n.s = dchp_pkg::SD_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign initial_selection_event       = q.initial_selection_event;
  assign poll      = q.poll;
  assign pend      = q.pend;
  assign busy_act  = (q.s == dchp_pkg::SD_BUSY);
  assign busy_sent = q.bsent;
  assign disc      = q.disc;
endmodule

//--- dchp_port.sv
// two-channel host port: selection, route switching, disconnect and data transfer control
`timescale 1ns/10ps
`include "dchp_defs.svh"
module dchp_port (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // channel sides
  input  wire dchp_pkg::dchp_otag_t chan_a_otag,
  input  wire dchp_pkg::dchp_otag_t chan_b_otag,
  output dchp_pkg::dchp_itag_t      chan_a_itag,
  output dchp_pkg::dchp_itag_t      chan_b_itag,
  // controller
  input  wire logic                 cmd_active,
  input  wire logic                 opt_two_channel,
  input  wire logic                 offset_mode,
  input  wire logic                 store_parity_error,
  input  wire logic                 register_parity_error,
  output logic                      mp_irq,
  output logic                      error_alarm,
  // formatter
  input  wire logic                 formatter_xfer_request,
  input  wire logic [7:0]           fmt_rd_data,
  output logic                      buffer_xfer_pulse,
  output logic [7:0]                fmt_wr_data
);
  dchp_pkg::dchp_st_t   q, n;
  dchp_pkg::dchp_otag_t act;
  dchp_pkg::dchp_otag_t tags_b;
  dchp_pkg::dchp_itag_t lk;
  logic [31:0]          rd;
  logic [31:0]          w;
  logic [7:0]           sts_out;
  logic                 ins_a, poll_a, pend_a, bact_a, bsent_a, disc_a;
  logic                 ins_b, poll_b, pend_b, bact_b, bsent_b, disc_b;
  logic                 busy_a, busy_b, ack_a, ack_b, resp, wdir;
  logic                 dly_start, dly_done, lo_fall, fr_rise;

  // inbound tags for one side: busy answer, linked drive, or quiet
  function automatic dchp_pkg::dchp_itag_t side_in(input logic bsy, input logic linked,
                                                   input logic req,
                                                   input dchp_pkg::dchp_itag_t l);
    dchp_pkg::dchp_itag_t r;
    r = '0;
    if (bsy) begin
      r.drv_en         = 1'b1;
      r.operational_in = 1'b1;
      r.status_in      = 1'b1;
      r.bus_in         = `DCHP_STS_CUB;
    end else if (linked) begin
      r = l;
    end
    r.request_in = req;
    return r;
  endfunction

  assign tags_b  = opt_two_channel ? chan_b_otag : '0;
  assign act     = q.route_b ? tags_b : chan_a_otag;
  assign sts_out = q.sts_byte | ((q.route_b ? bsent_b : bsent_a) ? `DCHP_STS_CUE : 8'h00);
  assign ack_a   = q.route_a & q.tag_sts & act.service_out & sts_out[5];
  assign ack_b   = q.route_b & q.tag_sts & act.service_out & sts_out[5];
  assign busy_a  = cmd_active | q.rst_busy | (opt_two_channel & q.in_use & q.route_b)
                   | q.rsv_b;
  assign busy_b  = cmd_active | q.rst_busy | (q.in_use & q.route_a) | q.rsv_a;
  assign resp    = act.service_out | act.data_out;
  assign wdir    = q.to_dev & ~q.src_mp;
  assign w       = hwdata;

  dchp_side u_side_a (
    .mclk      (mclk),
    .rst       (rst),
    .tags      (chan_a_otag),
    .cu_addr   (q.cu_addr),
    .poll_mode (q.req_a),
    .busy      (busy_a),
    .hold_off  (q.hold_a),
    .linked    (q.route_a & q.link_open),
    .end_ack   (ack_a),
    .initial_selection_event       (ins_a),
    .poll      (poll_a),
    .pend      (pend_a),
    .busy_act  (bact_a),
    .busy_sent (bsent_a),
    .disc      (disc_a)
  );

  dchp_side u_side_b (
    .mclk      (mclk),
    .rst       (rst),
    .tags      (tags_b),
    .cu_addr   (q.cu_addr),
    .poll_mode (q.req_b),
    .busy      (busy_b),
    .hold_off  (q.hold_b),
    .linked    (q.route_b & q.link_open),
    .end_ack   (ack_b),
    .initial_selection_event       (ins_b),
    .poll      (poll_b),
    .pend      (pend_b),
    .busy_act  (bact_b),
    .busy_sent (bsent_b),
    .disc      (disc_b)
  );

  dchp_dly u_dly (
    .mclk  (mclk),
    .rst   (rst),
    .start (dly_start),
    .done  (dly_done)
  );

  // register read decode
  always_comb begin
    rd = 32'h0;
    unique case (haddr[7:0])
      `DCHP_R_CTRL: begin
        rd[`DCHP_C_LINK]  = q.link_open;
        rd[`DCHP_C_HOLD]  = q.sw_hold;
        rd[`DCHP_C_RSVA]  = q.rsv_a;
        rd[`DCHP_C_RSVB]  = q.rsv_b;
        rd[`DCHP_C_DSI]   = q.dsi;
        rd[`DCHP_C_MRD]   = q.mrd;
        rd[`DCHP_C_TODEV] = q.to_dev;
        rd[`DCHP_C_TOHST] = q.to_host;
        rd[`DCHP_C_REL]   = q.rel;
        rd[`DCHP_C_RBSY]  = q.rst_busy;
        rd[`DCHP_C_DIN]   = q.use_din;
        rd[`DCHP_C_REQA]  = q.req_a;
        rd[`DCHP_C_REQB]  = q.req_b;
      end
      `DCHP_R_STAT: begin
        rd[`DCHP_S_RTA]   = q.route_a;
        rd[`DCHP_S_RTB]   = q.route_b;
        rd[`DCHP_S_USE]   = q.in_use;
        rd[`DCHP_S_HLDA]  = q.hold_a;
        rd[`DCHP_S_HLDB]  = q.hold_b;
        rd[`DCHP_S_BSA]   = bsent_a;
        rd[`DCHP_S_BSB]   = bsent_b;
        rd[`DCHP_S_FULL]  = q.full;
        rd[`DCHP_S_RWAIT] = q.resp_wait;
      end
      `DCHP_R_EVT: begin
        rd[`DCHP_E_INS]  = q.ev_ins;
        rd[`DCHP_E_POLL] = q.ev_poll;
        rd[`DCHP_E_DCN]  = q.ev_dcn;
        rd[`DCHP_E_XEND] = q.ev_xend;
        rd[`DCHP_E_OVR]  = q.ovr;
        rd[`DCHP_E_OVR2] = q.ovr2;
        rd[`DCHP_E_INSB] = q.ins_b;
        rd[`DCHP_E_PROCESS_ERROR] = q.process_error;
      end
      `DCHP_R_ITAG: rd = {21'h0, q.tag_opi, q.tag_sts, q.tag_adr, q.sts_byte};
      `DCHP_R_MBI:  rd = {24'h0, q.mbi};
      `DCHP_R_OTAG: rd = {16'h0, q.outtag};
      `DCHP_R_ADDR: rd = {27'h0, q.cu_addr};
      default:      rd = 32'h0;
    endcase
  end

  always_comb begin
    n = q;
    n.xfp     = 1'b0;
    n.rdy     = 1'b1;
    dly_start = 1'b0;
    lo_fall   = q.lo_q & ~q.link_open;
    n.lo_q    = q.link_open;
    fr_rise   = formatter_xfer_request & ~q.fr_q;
    n.fr_q    = formatter_xfer_request;

    // data phase of a register write
    if (q.hv && q.hw) begin
      unique case (q.ha)
        `DCHP_R_CTRL: begin
          n.link_open = w[`DCHP_C_LINK];
          n.sw_hold   = w[`DCHP_C_HOLD];
          n.rsv_a     = w[`DCHP_C_RSVA];
          n.rsv_b     = w[`DCHP_C_RSVB];
          n.dsi       = w[`DCHP_C_DSI];
          n.mrd       = w[`DCHP_C_MRD];
          n.to_dev    = w[`DCHP_C_TODEV];
          n.to_host   = w[`DCHP_C_TOHST];
          n.rel       = w[`DCHP_C_REL];
          n.rst_busy  = w[`DCHP_C_RBSY];
          n.use_din   = w[`DCHP_C_DIN];
          n.req_a     = w[`DCHP_C_REQA];
          n.req_b     = w[`DCHP_C_REQB];
        end
        `DCHP_R_EVT: begin
          n.ev_ins  = q.ev_ins & ~w[`DCHP_E_INS];
          n.ev_poll = q.ev_poll & ~w[`DCHP_E_POLL];
          n.ev_dcn  = q.ev_dcn & ~w[`DCHP_E_DCN];
          n.ev_xend = q.ev_xend & ~w[`DCHP_E_XEND];
          n.ovr     = q.ovr & ~w[`DCHP_E_OVR];
          n.ovr2    = q.ovr2 & ~w[`DCHP_E_OVR2];
          n.process_error    = q.process_error & ~w[`DCHP_E_PROCESS_ERROR];
        end
        `DCHP_R_ITAG: begin
          n.sts_byte = w[7:0];
          n.tag_adr  = w[`DCHP_T_ADR];
          n.tag_sts  = w[`DCHP_T_STS];
          n.tag_opi  = w[`DCHP_T_OPI];
        end
        `DCHP_R_MBI: begin
          n.mbi    = w[7:0];
          n.mbi_go = q.mrd;
        end
        `DCHP_R_ADDR: n.cu_addr = w[4:0];
        default: n.cu_addr = q.cu_addr;
      endcase
    end

    // address phase: read data is captured here, shown in the data phase
    n.hv = hsel & hready & htrans[1];
    if (n.hv) begin
      n.hw     = hwrite & (hsize == 3'h2);
      n.ha     = haddr[7:0];
      n.hrdata = hwrite ? 32'h0 : rd;
    end else begin
      n.hw = 1'b0;
    end

    // route control
    if (!opt_two_channel) begin
      n.route_a = 1'b1;
      n.route_b = 1'b0;
      n.in_use  = 1'b1;
      n.hold_a  = 1'b0;
      n.hold_b  = 1'b0;
    end else begin
      if (!q.in_use && (ins_a || poll_a)) begin
        n.in_use  = 1'b1;
        n.route_a = 1'b1;
        n.route_b = 1'b0;
      end else if (!q.in_use && (ins_b || poll_b)) begin
        n.in_use  = 1'b1;
        n.route_a = 1'b0;
        n.route_b = 1'b1;
      end
      if (lo_fall && q.in_use && (q.rel || (q.route_a ? pend_b : pend_a))) begin
        n.in_use  = 1'b0;
        n.route_a = 1'b0;
        n.route_b = 1'b0;
        n.rel     = 1'b0;
        n.hold_a  = 1'b0;
        n.hold_b  = 1'b0;
      end
      if (q.sw_hold && poll_a && q.route_a) begin
        n.hold_b = 1'b1;
      end
      if (q.sw_hold && poll_b && q.route_b) begin
        n.hold_a = 1'b1;
      end
    end
    if (ack_a || ack_b) begin
      n.sw_hold = 1'b0;
    end

    // selection events, set wins over a clear in the same cycle
    if ((ins_a && n.route_a) || (ins_b && n.route_b)) begin
      n.ev_ins = 1'b1;
      n.ins_b  = ins_b;
    end
    if (poll_a || poll_b) begin
      n.ev_poll = 1'b1;
    end

    // interface disconnect from the channel
    if (disc_a || disc_b) begin
      n.ev_dcn    = 1'b1;
      n.ev_xend   = 1'b1;
      n.link_open = 1'b0;
      n.tag_adr   = 1'b0;
      n.tag_sts   = 1'b0;
      n.tag_opi   = 1'b0;
    end

    // process error while linked traps into disconnect-in
    if ((store_parity_error || register_parity_error) && q.link_open) begin
      n.process_error = 1'b1;
      n.dsi  = 1'b1;
    end

    n.outtag = q.link_open ? act : '0;

    // transfer control
    if (fr_rise && q.full) begin
      n.ovr = 1'b1;
    end
    if (q.resp_wait && resp) begin
      n.resp_wait = 1'b0;
      if (wdir) begin
        n.xbuf = act.bus_out;
        n.full = 1'b1;
      end
    end
    unique case (q.xs)
      dchp_pkg::X_IDLE: begin
        if (q.link_open && q.mbi_go) begin
          n.xbuf   = q.mbi;
          n.full   = 1'b1;
          n.mbi_go = 1'b0;
          n.src_mp = 1'b1;
          n.xs     = dchp_pkg::X_REQ;
        end else if (q.link_open && q.to_dev && formatter_xfer_request && !q.xfp) begin
          n.xs = dchp_pkg::X_REQ;
        end else if (q.link_open && q.to_host && formatter_xfer_request && !q.xfp) begin
          n.xbuf = fmt_rd_data;
          n.xfp  = 1'b1;
          n.full = 1'b1;
          n.xs   = dchp_pkg::X_REQ;
        end
        dly_start = (n.xs == dchp_pkg::X_REQ);
        if (dly_start && offset_mode && q.resp_wait) begin
          n.ovr2 = 1'b1;
        end
      end
      dchp_pkg::X_REQ: begin
        if (resp) begin
          if (wdir) begin
            n.xbuf = act.bus_out;
            n.full = 1'b1;
          end
          n.xs = dchp_pkg::X_ACK;
        end else if (offset_mode && dly_done) begin
          n.resp_wait = 1'b1;
          n.xs        = dchp_pkg::X_ACK;
        end
      end
      dchp_pkg::X_ACK: begin
        if (wdir) begin
          if (!n.resp_wait && !resp) begin
            n.xs = dchp_pkg::X_PASS;
          end
        end else if (q.resp_wait || !resp) begin
          n.full   = 1'b0;
          n.src_mp = 1'b0;
          n.xs     = dchp_pkg::X_IDLE;
        end
      end
      dchp_pkg::X_PASS: begin
        n.xfp    = 1'b1;
        n.fmt_wd = q.xbuf;
        n.full   = 1'b0;
        n.xs     = dchp_pkg::X_IDLE;
      end
      default: n.xs = dchp_pkg::X_IDLE;
    endcase
    if (!q.link_open || disc_a || disc_b) begin
      n.xs        = dchp_pkg::X_IDLE;
      n.full      = 1'b0;
      n.resp_wait = 1'b0;
      n.src_mp    = 1'b0;
    end

    // inbound tags of the linked side
    lk                = '0;
    lk.drv_en         = n.link_open;
    lk.operational_in = n.tag_opi;
    lk.address_in     = n.tag_adr;
    lk.status_in      = n.tag_sts;
    lk.disconnect_in  = n.dsi;
    lk.service_in     = (n.xs == dchp_pkg::X_REQ) & ~n.use_din;
    lk.data_in        = (n.xs == dchp_pkg::X_REQ) & n.use_din;
    lk.bus_in         = n.tag_sts ? sts_out : n.xbuf;
    n.cin_a = side_in(bact_a, n.route_a & n.link_open, n.req_a, lk);
    n.cin_b = side_in(bact_b & opt_two_channel, n.route_b & n.link_open,
                      n.req_b & opt_two_channel, lk);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q         <= '0;
      q.cu_addr <= `DCHP_ADDR_RST;
    end else begin
      q <= n;
    end
  end

  assign hreadyout         = q.rdy;
  assign hresp             = 1'b0;
  assign hrdata            = q.hrdata;
  assign chan_a_itag       = q.cin_a;
  assign chan_b_itag       = q.cin_b;
  assign mp_irq            = q.ev_ins;
  assign error_alarm       = q.process_error;
  assign buffer_xfer_pulse = q.xfp;
  assign fmt_wr_data       = q.fmt_wd;
endmodule

//--- dchp_props.sv
// concurrent checks on the host port pins
`timescale 1ns/10ps
module dchp_props (
  // watched pins
  input wire logic                 mclk, rst, hreadyout, hresp, offset_mode,
  input wire logic                 opt_two_channel, store_parity_error, error_alarm,
  input wire logic                 buffer_xfer_pulse,
  input wire dchp_pkg::dchp_otag_t chan_a_otag,
  input wire dchp_pkg::dchp_itag_t chan_a_itag, chan_b_itag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic hs;
  assign hs = chan_a_itag.service_in | chan_a_itag.data_in;
  property p_rdy; !$past(rst) |-> hreadyout; endproperty
  property p_ok; hresp == 1'h0; endproperty
  property p_pls; buffer_xfer_pulse |=> !buffer_xfer_pulse; endproperty
  property p_bq; !opt_two_channel |-> chan_b_itag == '0; endproperty
  property p_ofs; offset_mode && $rose(hs) |-> ##[1:22] !hs; endproperty
  property p_nrm; !offset_mode && hs && !chan_a_otag.service_out |=> hs; endproperty
  property p_dcn; $rose(chan_a_otag.address_out) && !chan_a_otag.select_out
    && chan_a_itag.drv_en |-> ##[1:4] !chan_a_itag.drv_en; endproperty
  property p_alm; store_parity_error && chan_a_itag.drv_en
    |-> ##[1:6] error_alarm && chan_a_itag.disconnect_in; endproperty
  a_rdy: assert property (p_rdy) else $error("bus not ready");
  a_ok: assert property (p_ok) else $error("error response");
  a_pls: assert property (p_pls) else $error("pulse too long");
  a_bq: assert property (p_bq) else $error("side b driven");
  a_ofs: assert property (p_ofs) else $error("offset drop late");
  a_nrm: assert property (p_nrm) else $error("early drop");
  a_dcn: assert property (p_dcn) else $error("no disconnect");
  a_alm: assert property (p_alm) else $error("no alarm");
  c_pls: cover property (buffer_xfer_pulse);
  c_dcn: cover property ($fell(chan_a_itag.drv_en));
  c_alm: cover property ($rose(error_alarm));
endmodule
bind dchp_port dchp_props u_props (.mclk, .rst, .hreadyout, .hresp, .offset_mode,
  .opt_two_channel, .store_parity_error, .error_alarm, .buffer_xfer_pulse,
  .chan_a_otag, .chan_a_itag, .chan_b_itag);

//--- dchp_chan.sv
// channel side model: selection tags and byte handshake
`timescale 1ns/10ps
module dchp_chan (
  // bench control
  input wire logic                 mclk,
  input wire logic [1:0]           mode,
  input wire logic [4:0]           lat,
  input wire logic [7:0]           dat,
  // port pins
  input wire dchp_pkg::dchp_itag_t it,
  output dchp_pkg::dchp_otag_t     ot
);
  logic [4:0] n = 5'h0;
  logic       req;
  assign req = it.service_in | it.data_in | it.status_in;
  initial ot = '0;
  always @(posedge mclk) begin
    ot.select_out <= mode == 2'h1;
    ot.hold_out <= mode == 2'h1;
    ot.address_out <= mode != 2'h0;
    ot.operational_out <= 1'h1;
    n <= req ? n + 5'h1 : 5'h0;
    ot.service_out <= req && n >= lat;
    // released bus toggles so a stale byte never reads as valid
    ot.bus_out <= mode == 2'h1 ? 8'h0 : (req && n >= lat) ? dat : ~ot.bus_out;
  end
endmodule

//--- tb_dual_channel_host_port.sv
// self-checking bench for the dual channel host port
`timescale 1ns/10ps
module tb_dual_channel_host_port;
  logic                 mclk = 1'h0, rst = 1'h1, hwrite = 1'h0, cmd = 1'h0, ofs = 1'h0;
  logic                 spe = 1'h0, rpe = 1'h0, req = 1'h0, dtd = 1'h1, two = 1'h0;
  logic                 hreadyout, hresp, irq, alm, pls;
  logic [1:0]           htrans = 2'h0, mode = 2'h0, mode_b = 2'h0;
  logic [4:0]           lat = 5'h4;
  logic [7:0]           haddr = 8'h0, dat = 8'h0, frd = 8'h0, fwd;
  logic [31:0]          hwdata = 32'h0, hrdata, sd = 32'h2ca73e43;
  logic [31:0]          q[$];
  int                   num_errors = 0, num_checks = 0, cyc = 0;
  event                 rv;
  dchp_pkg::dchp_otag_t ota, otb;
  dchp_pkg::dchp_itag_t ita, itb;
  dchp_port DUT (.mclk, .rst, .hsel(1'h1), .haddr({24'h0, haddr}), .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .chan_a_otag(ota), .chan_b_otag(otb), .chan_a_itag(ita), .chan_b_itag(itb),
    .cmd_active(cmd), .opt_two_channel(two), .offset_mode(ofs), .store_parity_error(spe),
    .register_parity_error(rpe), .mp_irq(irq), .error_alarm(alm),
    .formatter_xfer_request(req), .fmt_rd_data(frd), .buffer_xfer_pulse(pls),
    .fmt_wr_data(fwd));
  dchp_chan u_chan (.mclk, .mode, .lat, .dat, .it(ita), .ot(ota));
  dchp_chan u_chan_b (.mclk, .mode(mode_b), .lat, .dat, .it(itb), .ot(otb));
  initial forever #5 mclk = ~mclk;
  function logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, s, e);
    end
  endtask
  task report_and_stop;
    // a note never taken off the queue means a result that never appeared
    if (q.size() != 0) num_errors++;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'h1) @(posedge mclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    q.push_back(e);
    ->rv;
  endtask
  // result watcher: oldest note against what appears
  always @(rv) chk(hrdata, q.pop_front());
  always @(posedge mclk) if (pls === 1'h1)
    chk({24'h0, dtd ? fwd : ita.bus_in}, q.pop_front());
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      report_and_stop;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    rd(8'h04, 32'h5);
    rd(8'h1c, 32'h0);
    cmd <= 1'h1;
    mode <= 2'h1;
    repeat (20) if (ita.status_in !== 1'h1) @(posedge mclk);
    chk({24'h0, ita.bus_in}, 32'h50);
    repeat (12) @(posedge mclk);
    mode <= 2'h0;
    cmd <= 1'h0;
    rd(8'h04, 32'h25);
    mode <= 2'h1;
    repeat (20) if (irq !== 1'h1) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    mode <= 2'h0;
    rd(8'h08, 32'h1);
    bus(8'h08, 1'h1, 32'h1);
    bus(8'h0c, 1'h1, 32'h200);
    bus(8'h00, 1'h1, 32'h41);
    repeat (3) @(posedge mclk);
    chk({24'h0, ita.bus_in}, 32'h20);
    bus(8'h0c, 1'h1, 32'h0);
    rd(8'h04, 32'h5);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) bus(8'h00, 1'h1, 32'h81);
      dtd = i < 2;
      ofs <= i == 3;
      lat <= i == 3 ? 5'h19 : 5'h1 << i;
      sd = nx(sd);
      dat <= sd[7:0];
      frd <= sd[15:8];
      q.push_back({24'h0, i < 2 ? sd[7:0] : sd[15:8]});
      req <= 1'h1;
      repeat (60) if (pls !== 1'h1) @(posedge mclk);
      req <= 1'h0;
      repeat (30) @(posedge mclk);
    end
    bus(8'h08, 1'h1, 32'hff);
    mode <= 2'h2;
    repeat (6) @(posedge mclk);
    mode <= 2'h0;
    rd(8'h08, 32'hc);
    rd(8'h00, 32'h80);
    bus(8'h00, 1'h1, 32'h1);
    @(posedge mclk);
    {spe, rpe} <= 2'h3;
    @(posedge mclk);
    {spe, rpe} <= 2'h0;
    repeat (20) if (alm !== 1'h1) @(posedge mclk);
    chk({31'h0, alm}, 32'h1);
    chk({31'h0, ita.disconnect_in}, 32'h1);
    bus(8'h00, 1'h1, 32'h0);
    rd(8'h00, 32'h0);
    // second reset with the switch option fitted: route starts neutral
    rst <= 1'h1;
    two <= 1'h1;
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    mode_b <= 2'h1;
    repeat (20) if (irq !== 1'h1) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    mode_b <= 2'h0;
    rd(8'h08, 32'h41);
    rd(8'h04, 32'h6);
    mode <= 2'h1;
    repeat (20) if (ita.status_in !== 1'h1) @(posedge mclk);
    chk({24'h0, ita.bus_in}, 32'h50);
    report_and_stop;
  end
endmodule
